// ### shared/drs_pkg.sv
package drs_pkg;

  localparam int          STATUS_BYTES    = 3;
  localparam logic [7:0]  BAD_TRACK_ID    = 8'hFF;
  localparam logic [7:0]  LAST_SECTOR_NUM = 8'hFF;

  localparam int          S0_IC_HI        = 7;
  localparam int          S0_IC_LO        = 6;
  localparam int          S0_SEEK_BIT     = 5;
  localparam int          S0_TRACK_ZERO_SENSE_BIT     = 4;
  localparam int          S0_HEAD_BIT     = 2;
  localparam int          S1_END_BIT      = 7;
  localparam int          S1_CRC_BIT      = 5;
  localparam int          S1_OVR_BIT      = 4;
  localparam int          S1_NODATA_BIT   = 2;
  localparam int          S1_WP_BIT       = 1;
  localparam int          S1_ID_AM_BIT    = 0;
  localparam int          S2_CM_BIT       = 6;
  localparam int          S2_DD_BIT       = 5;
  localparam int          S2_WC_BIT       = 4;
  localparam int          S2_BC_BIT       = 1;
  localparam int          S2_MD_BIT       = 0;

  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [1:0]  INDEX_LIMIT     = 2'h2;

  localparam logic [1:0]  IC_NORMAL       = 2'h0;
  localparam logic [1:0]  IC_ABNORMAL     = 2'h1;
  localparam logic [1:0]  IC_INVALID      = 2'h2;
  localparam logic [1:0]  IC_POLLING      = 2'h3;

  typedef struct packed {
    logic       seek_done;
    logic       recal_done;
    logic       rel_seek_under;
    logic       invalid_cmd;
    logic       polling_stop;
    logic       abnormal;
    logic       sector_past_end;
    logic       rw_no_tc;
    logic       id_crc_err;
    logic       data_crc_err;
    logic       service_late;
    logic       sector_not_found;
    logic       id_unreadable;
    logic       track_seq_err;
    logic       write_cmd;
    logic       read_data_cmd;
    logic       read_deleted_cmd;
    logic       saw_deleted_mark;
    logic       saw_data_mark;
    logic       data_mark_absent;
    logic       id_seen;
    logic [7:0] id_track;
  } drs_event_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_RESLT = 3'b100
  } drs_state_type;

endpackage : drs_pkg

// ### rtl/drs_pin_sync.sv
module drs_pin_sync
  import drs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Change taken only when stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule : drs_pin_sync

// ### rtl/drs_status_encoder.sv
// Function
// [RULE_01] Result bytes go out via data register
// [RULE_02] Byte0 bits 7:6 give termination class
// [RULE_03] Byte0 bit5 set on positioning completion
// [RULE_04] Byte0 bit4 set on track-zero fault
// [RULE_05] Byte0 holds head bit2, unit bits1:0
// [RULE_06] Byte1 bit7 set on end of track
// [RULE_07] Byte1 bit5 set on any CRC fault
// [RULE_08] Byte1 bit4 set on overrun or underrun
// [RULE_09] Byte1 bit2 set when sector missing
// [RULE_10] Byte1 bit1 set on write-protect during write
// [RULE_11] Byte1 bit0 set on missing address mark
// [RULE_12] Byte2 bit6 set on deleted mark mismatch
// [RULE_13] Byte2 bit5 set on data-field CRC fault
// [RULE_14] Byte2 bit4 set on track mismatch
// [RULE_15] Byte2 bit1 set on bad track FF
// [RULE_16] Byte2 bit0 set when data mark absent
// [RULE_17] Unused status bits always read zero
// [RULE_18] Host reads only when request and direction set
// [RULE_19] Bytes served in order zero, one, two
module drs_status_encoder
  import drs_pkg::*;
#(
  parameter int NUM_BYTES = STATUS_BYTES
)
(
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic          soft_reset,
  input  wire logic          cmd_start,
  input  wire logic          cmd_end,
  input  wire logic          cmd_has_result,
  input  wire drs_event_type events,
  input  wire logic          track_zero_sense,
  input  wire logic          write_protect_pin,
  input  wire logic          rotation_marker_n,
  input  wire logic          transfer_count_done,
  input  wire logic          head_sel,
  input  wire logic [1:0]    unit_select,
  input  wire logic [7:0]    internal_track,
  input  wire logic          data_rd,
  output logic [7:0]         data_out,
  output logic               host_req_flag,
  output logic               transfer_direction,
  output logic               result_busy,
  output logic               result_done
);

  drs_state_type state_reg;
  logic [7:0]    result_status_zero;
  logic [7:0]    result_status_one;
  logic [7:0]    result_status_two;
  logic [1:0]    byte_idx_reg;
  logic [1:0]    index_cnt_reg;
  logic          track_zero_sense_s;
  logic          wp_s;
  logic          idx_n_s;
  logic          idx_prev_reg;
  logic          tc_seen_reg;
  logic          rst_all;
  logic          ev_track_zero_sense_fault;
  logic          ev_wp_hit;
  logic          ev_id_absent;
  logic          ev_end_track;
  logic          idx_pulse;
  logic          rd_ok;
  logic          last_byte;
  logic [7:0]    byte_sel;
  logic          ev_crc_any;
  logic          ev_no_sector;
  logic          ev_mark_clash;
  logic          ev_track_mis;
  logic          ev_bad_track;
  logic          ev_mark_absent;

  // Pins from the drive are asynchronous to ref_clk
  drs_pin_sync u_sync_track_zero_sense (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pin_in    (track_zero_sense),
    .level_out (track_zero_sense_s)
  );
  drs_pin_sync u_sync_wp (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pin_in    (write_protect_pin),
    .level_out (wp_s)
  );
  drs_pin_sync u_sync_idx (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pin_in    (rotation_marker_n),
    .level_out (idx_n_s)
  );

  assign rst_all   = !rstn || soft_reset;
  assign idx_pulse = idx_prev_reg && !idx_n_s;
  assign last_byte = (byte_idx_reg == 2'(NUM_BYTES - 1));
  assign rd_ok     = (state_reg == ST_RESLT) && data_rd && host_req_flag
                     && transfer_direction; // [RULE_18]

  // Track-zero still low after recalibrate, or outward past zero
  assign ev_track_zero_sense_fault = (events.recal_done && !track_zero_sense_s) || events.rel_seek_under; // [RULE_04]
  assign ev_wp_hit     = events.write_cmd && wp_s; // [RULE_10]
  assign ev_id_absent  = (index_cnt_reg == INDEX_LIMIT) && !events.id_seen; // [RULE_11]
  // A read/write ending without terminal count also counts as past end
  assign ev_end_track  = events.sector_past_end
                         || (cmd_end && events.rw_no_tc && !tc_seen_reg); // [RULE_06]
  // Either CRC error lands in byte one, data-field only in byte two
  assign ev_crc_any     = events.id_crc_err || events.data_crc_err; // [RULE_07]
  assign ev_no_sector   = events.sector_not_found || events.id_unreadable
                          || events.track_seq_err; // [RULE_09]
  assign ev_mark_clash  = (events.read_data_cmd && events.saw_deleted_mark)
                          || (events.read_deleted_cmd && events.saw_data_mark); // [RULE_12]
  // Identifier track only meaningful in the cycle it is seen
  assign ev_track_mis   = events.id_seen && (events.id_track != internal_track); // [RULE_14]
  assign ev_bad_track   = ev_track_mis && (events.id_track == BAD_TRACK_ID); // [RULE_15]
  assign ev_mark_absent = ev_id_absent || events.data_mark_absent; // [RULE_11]

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cmd_start) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (cmd_end) begin
            state_reg <= cmd_has_result ? ST_RESLT : ST_IDLE;
          end
        end
        ST_RESLT: begin
          if (rd_ok && last_byte) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Index pulses counted per command for the address mark timeout
  // Previous level resets like the synchroniser, so no false edge
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      idx_prev_reg  <= 1'b0;
      index_cnt_reg <= 2'h0;
    end else begin
      idx_prev_reg <= idx_n_s;
      if (cmd_start) begin
        index_cnt_reg <= 2'h0;
      end else if (state_reg == ST_EXEC && idx_pulse && index_cnt_reg != INDEX_LIMIT) begin
        index_cnt_reg <= index_cnt_reg + 2'h1; // [RULE_11]
      end
    end
  end

  // Terminal count remembered so end of track is judged at command end
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      tc_seen_reg <= 1'b0;
    end else if (cmd_start) begin
      tc_seen_reg <= 1'b0;
    end else if (state_reg == ST_EXEC && transfer_count_done) begin
      tc_seen_reg <= 1'b1; // [RULE_06]
    end
  end

  // Status byte zero; flags accumulate across execution, cleared at start
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      result_status_zero <= STATUS_RESET;
    end else if (cmd_start) begin
      result_status_zero <= STATUS_RESET;
    end else if (state_reg == ST_EXEC) begin
      if (events.invalid_cmd) begin
        result_status_zero[S0_IC_HI:S0_IC_LO] <= IC_INVALID; // [RULE_02]
      end else if (events.polling_stop) begin
        result_status_zero[S0_IC_HI:S0_IC_LO] <= IC_POLLING; // [RULE_02]
      end else if (events.abnormal || ev_track_zero_sense_fault) begin
        result_status_zero[S0_IC_HI:S0_IC_LO] <= IC_ABNORMAL; // [RULE_02]
      end
      if (events.seek_done || events.recal_done) begin
        result_status_zero[S0_SEEK_BIT] <= 1'b1; // [RULE_03]
      end
      if (ev_track_zero_sense_fault) begin
        result_status_zero[S0_TRACK_ZERO_SENSE_BIT] <= 1'b1; // [RULE_04]
      end
      // Identity captured live so the final head and unit are reported
      result_status_zero[S0_HEAD_BIT] <= head_sel; // [RULE_05]
      result_status_zero[1:0]         <= unit_select; // [RULE_05]
      result_status_zero[3]           <= 1'b0; // [RULE_17]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      result_status_one <= STATUS_RESET;
    end else if (cmd_start) begin
      result_status_one <= STATUS_RESET;
    end else if (state_reg == ST_EXEC) begin
      // Byte one flags stay set until the next command starts
      if (ev_end_track) begin
        result_status_one[S1_END_BIT] <= 1'b1; // [RULE_06]
      end
      if (ev_crc_any) begin
        result_status_one[S1_CRC_BIT] <= 1'b1; // [RULE_07]
      end
      if (events.service_late) begin
        result_status_one[S1_OVR_BIT] <= 1'b1; // [RULE_08]
      end
      if (ev_no_sector) begin
        result_status_one[S1_NODATA_BIT] <= 1'b1; // [RULE_09]
      end
      if (ev_wp_hit) begin
        result_status_one[S1_WP_BIT] <= 1'b1; // [RULE_10]
      end
      if (ev_mark_absent) begin
        result_status_one[S1_ID_AM_BIT] <= 1'b1; // [RULE_11]
      end
      result_status_one[6] <= 1'b0; // [RULE_17]
      result_status_one[3] <= 1'b0; // [RULE_17]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      result_status_two <= STATUS_RESET;
    end else if (cmd_start) begin
      result_status_two <= STATUS_RESET;
    end else if (state_reg == ST_EXEC) begin
      if (ev_mark_clash) begin
        result_status_two[S2_CM_BIT] <= 1'b1; // [RULE_12]
      end
      if (events.data_crc_err) begin
        result_status_two[S2_DD_BIT] <= 1'b1; // [RULE_13]
      end
      if (ev_track_mis) begin
        result_status_two[S2_WC_BIT] <= 1'b1; // [RULE_14]
      end
      if (ev_bad_track) begin
        result_status_two[S2_BC_BIT] <= 1'b1; // [RULE_15]
      end
      if (events.data_mark_absent) begin
        result_status_two[S2_MD_BIT] <= 1'b1; // [RULE_16]
      end
      result_status_two[7] <= 1'b0; // [RULE_17]
      result_status_two[3] <= 1'b0; // [RULE_17]
      result_status_two[2] <= 1'b0; // [RULE_17]
    end
  end

  // Byte sequencing and host-facing flags
  always_comb begin
    case (byte_idx_reg)
      2'h0:    byte_sel = result_status_zero;
      2'h1:    byte_sel = result_status_one;
      2'h2:    byte_sel = result_status_two;
      default: byte_sel = STATUS_RESET;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      byte_idx_reg <= 2'h0;
    end else if (state_reg != ST_RESLT) begin
      byte_idx_reg <= 2'h0;
    end else if (rd_ok && !last_byte) begin
      byte_idx_reg <= byte_idx_reg + 2'h1; // [RULE_19]
    end
  end

  // One cycle of request low after each read lets the next byte settle
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      host_req_flag <= 1'b0;
    end else begin
      host_req_flag <= (state_reg == ST_RESLT) && !rd_ok;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      data_out <= STATUS_RESET;
    end else begin
      data_out <= byte_sel; // [RULE_01]
    end
  end

  // Direction drops with the last read so the host sees no stale request
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      transfer_direction <= 1'b0;
    end else begin
      transfer_direction <= (state_reg == ST_RESLT) && !(rd_ok && last_byte);
    end
  end

  // Busy lags the state by one cycle; a limitation the host must allow for
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      result_busy <= 1'b0;
    end else begin
      result_busy <= (state_reg != ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      result_done <= 1'b0;
    end else begin
      result_done <= rd_ok && last_byte; // [RULE_19]
    end
  end

endmodule : drs_status_encoder

// ### verif/drs_status_encoder_sva.sv
module drs_status_encoder_sva
  import drs_pkg::*;
#(
  parameter int NUM_BYTES = STATUS_BYTES
)
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       soft_reset,
  input wire logic       cmd_start,
  input wire logic       data_rd,
  input wire logic [7:0] data_out,
  input wire logic       host_req_flag,
  input wire logic       transfer_direction,
  input wire logic       result_done
);
  localparam logic [1:0] LAST_IDX = 2'(NUM_BYTES - 1);
  logic [1:0] idx_reg;
  // Read count tells which byte is shown
  always_ff @(posedge ref_clk) begin
    if (!rstn || soft_reset || cmd_start) idx_reg <= 2'h0;
    else if (data_rd && host_req_flag && transfer_direction)
      idx_reg <= (idx_reg == LAST_IDX) ? 2'h0 : idx_reg + 2'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_read; data_rd && host_req_flag && transfer_direction; endsequence
  sequence s_gap; !host_req_flag ##1 host_req_flag; endsequence
  property p_spare0; host_req_flag && idx_reg == 2'h0 |-> !data_out[3]; endproperty
  a_spare0: assert property (p_spare0) else $error("byte0 spare bit set");
  property p_spare1; host_req_flag && idx_reg == 2'h1 |-> !data_out[6] && !data_out[3]; endproperty
  a_spare1: assert property (p_spare1) else $error("byte1 spare bit set");
  property p_spare2;
    host_req_flag && idx_reg == 2'h2 |-> !data_out[7] && !data_out[3] && !data_out[2];
  endproperty
  a_spare2: assert property (p_spare2) else $error("byte2 spare bit set");
  property p_dir; host_req_flag |-> transfer_direction; endproperty
  a_dir: assert property (p_dir) else $error("request without read direction");
  property p_next; s_read ##0 (idx_reg != LAST_IDX) |=> s_gap; endproperty
  a_next: assert property (p_next) else $error("next byte not offered");
  property p_done; s_read ##0 (idx_reg == LAST_IDX) |-> ##[1:2] result_done; endproperty
  a_done: assert property (p_done) else $error("no done after last byte");
  property p_stable;
    host_req_flag && !data_rd && !soft_reset && !cmd_start |=> $stable(data_out) && host_req_flag;
  endproperty
  a_stable: assert property (p_stable) else $error("byte moved without read");
  property p_soft;
    soft_reset |=> data_out == 8'h00 && !host_req_flag && !transfer_direction && !result_done;
  endproperty
  a_soft: assert property (p_soft) else $error("outputs live after soft reset");
endmodule : drs_status_encoder_sva

bind drs_status_encoder drs_status_encoder_sva #(.NUM_BYTES(NUM_BYTES)) drs_status_encoder_sva_i (
  .ref_clk, .rstn, .soft_reset, .cmd_start, .data_rd, .data_out, .host_req_flag,
  .transfer_direction, .result_done
);

// ### verif/drs_host_model.sv
module drs_host_model
(
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic host_req_flag,
  input  wire logic transfer_direction,
  output logic      data_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned dly = 0;
  initial data_rd = 1'h0;
  // Random think time mixes prompt and slow reads
  always @(posedge ref_clk) begin
    #1;
    if (data_rd || !rstn) data_rd = 1'h0;
    else if (host_req_flag && transfer_direction) begin
      if (dly == 0) begin
        data_rd = 1'h1;
        dly = $urandom_range(3);
      end
      else dly--;
    end
  end
endmodule : drs_host_model

// ### verif/test_drs_status_encoder.sv
module test_drs_status_encoder;
  timeunit 1ns;
  timeprecision 1ps;
  import drs_pkg::*;
  logic          ref_clk = 1'h0, rstn = 1'h0, soft_reset = 1'h0, cmd_start = 1'h0;
  logic          cmd_end = 1'h0, cmd_has_result = 1'h0, track_zero_sense = 1'h0;
  logic          write_protect_pin = 1'h0, rotation_marker_n = 1'h1, transfer_count_done = 1'h0;
  logic          head_sel = 1'h0;
  logic [1:0]    unit_select = 2'h0;
  logic [7:0]    internal_track = 8'h00;
  drs_event_type events = '0;
  logic          data_rd, host_req_flag, transfer_direction, result_busy, result_done;
  logic [7:0]    data_out;
  logic [7:0]    exp_q[$];
  int            n_fail = 0, tests_run = 0;

  always #10 ref_clk = ~ref_clk;

  drs_status_encoder drs_status_encoder_i (
    .ref_clk, .rstn, .soft_reset, .cmd_start, .cmd_end, .cmd_has_result, .events,
    .track_zero_sense, .write_protect_pin, .rotation_marker_n, .transfer_count_done,
    .head_sel, .unit_select, .internal_track, .data_rd, .data_out, .host_req_flag,
    .transfer_direction, .result_busy, .result_done
  );
  drs_host_model drs_host_model_i (.ref_clk, .rstn, .host_req_flag, .transfer_direction, .data_rd);

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  function automatic logic [23:0] ref_bytes(drs_event_type e, logic tz, wp, tc, ix);
    logic       ec;
    logic       wc;
    logic [1:0] ic;
    ec = e.rel_seek_under | (e.recal_done & !tz);
    wc = e.id_seen & (e.id_track != internal_track);
    ic = e.invalid_cmd ? IC_INVALID : e.polling_stop ? IC_POLLING :
         (e.abnormal | ec) ? IC_ABNORMAL : IC_NORMAL;
    return {ic, e.seek_done | e.recal_done, ec, 1'h0, head_sel, unit_select,
      e.sector_past_end | (e.rw_no_tc & !tc), 1'h0, e.id_crc_err | e.data_crc_err,
      e.service_late, 1'h0, e.sector_not_found | e.id_unreadable | e.track_seq_err,
      e.write_cmd & wp, e.data_mark_absent | (ix & !e.id_seen), 1'h0,
      (e.read_data_cmd & e.saw_deleted_mark) | (e.read_deleted_cmd & e.saw_data_mark),
      e.data_crc_err, wc, 2'h0, wc & (e.id_track == BAD_TRACK_ID),
      e.data_mark_absent};
  endfunction : ref_bytes

  // First flags one at a time, then sparse random mixes
  task automatic run_cmd(input int i);
    drs_event_type e;
    logic          tz, wp, tc, ix, hr;
    logic [23:0]   b;
    int            k;
    if (i < 21) e = drs_event_type'(29'h1 << (28 - i));
    else e = drs_event_type'(29'($urandom & $urandom & $urandom));
    e.id_track = (i % 3 == 0) ? BAD_TRACK_ID : 8'($urandom);
    {tz, wp, tc, ix} = 4'($urandom);
    hr = (i != 30);
    track_zero_sense = tz;
    write_protect_pin = wp;
    {head_sel, unit_select, internal_track} = 11'($urandom);
    b = ref_bytes(e, tz, wp, tc, ix);
    // Pins settle through the synchronisers before the command
    repeat (5) @(posedge ref_clk);
    #1 cmd_start = 1'h1;
    @(posedge ref_clk);
    #1 cmd_start = 1'h0;
    events = e;
    for (k = 0; k < 16; k++) begin
      rotation_marker_n = !(ix && k % 5 < 2 && k < 10);
      transfer_count_done = tc && k == 12;
      @(posedge ref_clk);
      #1;
    end
    cmd_end = 1'h1;
    cmd_has_result = hr;
    if (hr) for (k = 0; k < 3; k++) exp_q.push_back(b[23 - 8 * k -: 8]);
    @(posedge ref_clk);
    #1 cmd_end = 1'h0;
    events = '0;
    for (k = 0; hr && result_done !== 1'h1 && k < 200; k++) @(posedge ref_clk) #1;
    if (hr) check("result_done", {7'h00, result_done}, 8'h01);
    else begin
      repeat (4) @(posedge ref_clk);
      #1 check("result_busy", {7'h00, result_busy}, 8'h00);
    end
  endtask : run_cmd

  always @(negedge ref_clk) begin
    if (rstn && data_rd && host_req_flag === 1'h1 && transfer_direction === 1'h1) begin
      if (exp_q.size() == 0) check("surplus byte", data_out, 8'hXX);
      else check("result byte", data_out, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    conclude();
  end

  initial begin
    void'($urandom(32'h7A65));
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1'h1;
    for (int i = 0; i < 60; i++) run_cmd(i);
    cmd_start = 1'h1;
    @(posedge ref_clk);
    #1 cmd_start = 1'h0;
    soft_reset = 1'h1;
    @(posedge ref_clk);
    #1 soft_reset = 1'h0;
    cmd_end = 1'h1;
    @(posedge ref_clk);
    #1 cmd_end = 1'h0;
    repeat (4) @(posedge ref_clk);
    #1 check("busy after soft reset", {7'h00, result_busy}, 8'h00);
    conclude();
  end
endmodule : test_drs_status_encoder
